// ---- common/asu_consts.vh ----
// constants for the asynchronous serial transceiver (8/9-bit frames)
// assumes: included by bare name from rtl files; definitions only
//
// What this block does
// - frame_length_select picks 8-bit or 9-bit frames
// - 8-bit frame: start, 8 data LSB first, stop
// - accepted 8-bit frame: stop bit into received_ninth_bit
// - write to data_buffer_reg starts a transmission
// - tx_done_flag set when stop bit time begins
// - receiver accepts frames only while rx_enable set; only the start edge is gated, so a frame under way still loads
// - 8-bit load needs rx_done clear, stop=1 if checking
// - overrun keeps first byte, later bits discarded
// - failed load leaves buffer, ninth bit, flag alone
// - interrupt when either done flag sets, if enabled
// - 9-bit frame: start, 8 data, ninth, stop
// - transmitted ninth bit equals tx_ninth_bit
// - 9-bit receive stores ninth bit, ignores stop
// - 9-bit load needs rx_done clear, ninth=1 if checking
// - accepted 9-bit frame stores data, ninth, sets rx_done
`ifndef ASU_CONSTS_VH
`define ASU_CONSTS_VH

// ----------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------
`define ASU_OFF_CTRL 8'h00
`define ASU_OFF_DATA 8'h04
`define ASU_OFF_STAT 8'h08
`define ASU_OFF_MASK 8'h0C

// ----------------------------------------
// serial_control_reg field positions
// ----------------------------------------
`define ASU_CTL_TX9 3
`define ASU_CTL_REN 4
`define ASU_CTL_MCE 5
`define ASU_CTL_MODE 7
`define ASU_CTL_RESET 8'h00

// ----------------------------------------
// status and mask field positions
// ----------------------------------------
`define ASU_ST_TXD 0
`define ASU_ST_RXD 1
`define ASU_ST_RB9 2
`define ASU_ST_BUSY 3
`define ASU_ST_RXACT 4
`define ASU_MASK_RESET 2'h0

// ----------------------------------------
// bit timing: ticks are 16x the bit rate
// ----------------------------------------
`define ASU_OVS_LAST 4'hF
`define ASU_HALF_LAST 4'h7
`define ASU_LAST_BIT8 4'h7
`define ASU_LAST_BIT9 4'h8

`endif

// ---- rtl/asu_rx.v ----
// receive framer: start detect, centre sampling, 8 or 9 data bits, stop
// assumes: serial input already synchronised; tick is a 16x bit-rate strobe
`include "asu_consts.vh"
`default_nettype none

module asu_rx (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire tick_i,
    input wire rxd_i,
    input wire enable_i,
    input wire nine_i,
    output reg frame_o,
    output wire [7:0] data_o,
    output wire ninth_o,
    output reg stop_o,
    output wire active_o
);

    // ----------------------------------------
    // state codes, one-hot
    // ----------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_START = 4'h2;
    localparam [3:0] ST_DATA = 4'h4;
    localparam [3:0] ST_STOP = 4'h8;

    reg [3:0] state_reg; // framer state
    reg [3:0] tick_cnt_reg; // ticks inside the current bit
    reg [3:0] bit_idx_reg; // data bit being sampled
    reg [8:0] shift_reg; // received bits by index
    reg rxd_prev_reg; // previous line level for edge detect

    assign data_o = shift_reg[7:0];
    assign ninth_o = shift_reg[8];
    assign active_o = ~state_reg[0];

    // ----------------------------------------
    // framer
    // ----------------------------------------
    // frame_o pulses for one cycle at the centre of the stop bit
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            tick_cnt_reg <= 4'h0;
            bit_idx_reg <= 4'h0;
            shift_reg <= 9'h000;
            rxd_prev_reg <= 1'b1;
            frame_o <= 1'b0;
            stop_o <= 1'b1;
        end else if (ce_i) begin
            rxd_prev_reg <= rxd_i;
            frame_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // falling edge while enabled opens a frame
                    if (enable_i && rxd_prev_reg && !rxd_i) begin
                        state_reg <= ST_START;
                        tick_cnt_reg <= 4'h0;
                    end
                end
                ST_START: begin
                    if (tick_i) begin
                        if (tick_cnt_reg == `ASU_HALF_LAST) begin
                            // glitch shorter than half a bit is dropped
                            tick_cnt_reg <= 4'h0;
                            bit_idx_reg <= 4'h0;
                            state_reg <= rxd_i ? ST_IDLE : ST_DATA;
                        end else begin
                            tick_cnt_reg <= tick_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_DATA: begin
                    if (tick_i) begin
                        if (tick_cnt_reg == `ASU_OVS_LAST) begin
                            tick_cnt_reg <= 4'h0;
                            shift_reg[bit_idx_reg] <= rxd_i;
                            // ninth data bit only in the long format
                            if (bit_idx_reg == (nine_i ? `ASU_LAST_BIT9 : `ASU_LAST_BIT8)) begin
                                state_reg <= ST_STOP;
                            end else begin
                                bit_idx_reg <= bit_idx_reg + 4'h1;
                            end
                        end else begin
                            tick_cnt_reg <= tick_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_STOP: begin
                    if (tick_i) begin
                        if (tick_cnt_reg == `ASU_OVS_LAST) begin
                            stop_o <= rxd_i;
                            frame_o <= 1'b1;
                            tick_cnt_reg <= 4'h0;
                            state_reg <= ST_IDLE;
                        end else begin
                            tick_cnt_reg <= tick_cnt_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- rtl/asu_top.v ----
// top of the asynchronous serial transceiver with apb register slave
// assumes: apb master on CLK_SYS_I; BAUD_TICK_I is a 16x bit-rate strobe
// from logic on the same clock; the serial input pin is asynchronous
`include "asu_consts.vh"
`default_nettype none

module asu_top (
    input wire CLK_SYS_I,
    input wire RST_I,
    input wire CE_I,
    input wire BAUD_TICK_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    input wire SERIAL_IN_PIN_I,
    output reg SERIAL_OUT_PIN_O,
    output reg IRQ_O
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // sticky flag update: a hardware set wins over a software clear
    function flag_next;
        input cur;
        input set;
        input clr;
        begin
            flag_next = set | (cur & ~clr);
        end
    endfunction

    // ----------------------------------------
    // transmitter state codes, one-hot
    // ----------------------------------------
    localparam [3:0] TX_IDLE = 4'h1;
    localparam [3:0] TX_START = 4'h2;
    localparam [3:0] TX_DATA = 4'h4;
    localparam [3:0] TX_STOP = 4'h8;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg [7:0] ctrl_reg; // serial_control_reg
    reg [7:0] data_buffer_reg; // received byte, read side of data register
    reg received_ninth_bit; // stop bit or ninth bit of last accepted frame
    reg tx_done_flag; // sticky, set at start of stop bit time
    reg rx_done_flag; // sticky, set when a frame is loaded
    reg [1:0] mask_reg; // interrupt enables, same layout as status
    reg sin_meta_reg; // pin synchroniser, first stage
    reg sin_sync_reg; // pin synchroniser, second stage

    reg [3:0] tx_state_reg; // transmitter state
    reg [3:0] tx_tick_reg; // ticks inside the current bit
    reg [3:0] tx_bit_reg; // data bit being sent
    reg [8:0] tx_shift_reg; // byte plus ninth bit to send
    reg tx_nine_reg; // format latched at start of frame

    wire frame_length_select = ctrl_reg[`ASU_CTL_MODE];
    wire rx_enable = ctrl_reg[`ASU_CTL_REN];
    wire multiproc_check_enable = ctrl_reg[`ASU_CTL_MCE];
    wire tx_ninth_bit = ctrl_reg[`ASU_CTL_TX9];

    wire rx_frame; // one-cycle pulse, frame ended
    wire [7:0] rx_data; // data bits of that frame
    wire rx_ninth; // ninth bit of that frame
    wire rx_stop; // stop bit of that frame
    wire rx_active; // framer busy

    // apb phases: ready goes out on the second access cycle
    wire apb_access = PSEL_I & PENABLE_I & CE_I;
    wire apb_done = apb_access & PREADY_O;
    wire apb_wr = apb_done & PWRITE_I;
    // whole byte address compared: a misaligned or out-of-range word misses
    wire hit_ctrl = (PADDR_I == `ASU_OFF_CTRL);
    wire hit_data = (PADDR_I == `ASU_OFF_DATA);
    wire hit_stat = (PADDR_I == `ASU_OFF_STAT);
    wire hit_mask = (PADDR_I == `ASU_OFF_MASK);
    wire hit_any = hit_ctrl | hit_data | hit_stat | hit_mask;

    wire tx_idle = tx_state_reg[0];
    // a write while a frame is going out is dropped
    wire tx_go = apb_wr & hit_data & tx_idle;
    wire tx_enter_stop; // last data bit finished

    // the ninth received bit that gates loading depends on the format
    wire rx_check_bit = frame_length_select ? rx_ninth : rx_stop;
    // overrun: rx_done_flag still set keeps the first byte in place
    wire rx_load = rx_frame & ~rx_done_flag &
        (~multiproc_check_enable | rx_check_bit);

    // status clear strobes, write one to clear
    wire clr_tx = apb_wr & hit_stat & PWDATA_I[`ASU_ST_TXD];
    wire clr_rx = apb_wr & hit_stat & PWDATA_I[`ASU_ST_RXD];

    // ----------------------------------------
    // serial input synchroniser
    // ----------------------------------------
    // two flops before any logic looks at the asynchronous pin
    // the framer reads only the second stage, never the first
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            sin_meta_reg <= 1'b1;
            sin_sync_reg <= 1'b1;
        end else if (CE_I) begin
            sin_meta_reg <= SERIAL_IN_PIN_I;
            sin_sync_reg <= sin_meta_reg;
        end
    end

    // ----------------------------------------
    // receiver framer
    // ----------------------------------------
    // format is passed live, so a mode change mid-frame applies at once
    asu_rx u_rx (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .tick_i(BAUD_TICK_I),
        .rxd_i(sin_sync_reg),
        .enable_i(rx_enable),
        .nine_i(frame_length_select),
        .frame_o(rx_frame),
        .data_o(rx_data),
        .ninth_o(rx_ninth),
        .stop_o(rx_stop),
        .active_o(rx_active)
    );

    // ----------------------------------------
    // apb slave: ready, read data, error
    // ----------------------------------------
    // one wait state; read data captured in the first access cycle
    // a low clock enable stalls the handshake, ready simply holds
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h00000000;
        end else if (CE_I) begin
            PREADY_O <= apb_access & ~PREADY_O;
            PSLVERR_O <= apb_access & ~PREADY_O & ~hit_any;
            if (apb_access && !PREADY_O && !PWRITE_I) begin
                PRDATA_O <= 32'h00000000;
                // unmapped addresses read as zero and flag an error
                if (hit_ctrl) begin
                    PRDATA_O[7:0] <= ctrl_reg;
                end
                if (hit_data) begin
                    PRDATA_O[7:0] <= data_buffer_reg;
                end
                if (hit_stat) begin
                    PRDATA_O[`ASU_ST_TXD] <= tx_done_flag;
                    PRDATA_O[`ASU_ST_RXD] <= rx_done_flag;
                    PRDATA_O[`ASU_ST_RB9] <= received_ninth_bit;
                    PRDATA_O[`ASU_ST_BUSY] <= ~tx_idle;
                    PRDATA_O[`ASU_ST_RXACT] <= rx_active;
                end
                if (hit_mask) begin
                    PRDATA_O[1:0] <= mask_reg;
                end
            end
        end
    end

    // ----------------------------------------
    // control and mask registers
    // ----------------------------------------
    // all eight control bits are kept; unused ones read back as written
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ctrl_reg <= `ASU_CTL_RESET;
            mask_reg <= `ASU_MASK_RESET;
        end else if (CE_I) begin
            if (apb_wr && hit_ctrl) begin
                ctrl_reg <= PWDATA_I[7:0];
            end
            if (apb_wr && hit_mask) begin
                mask_reg <= PWDATA_I[1:0];
            end
        end
    end

    // ----------------------------------------
    // receive buffer and done flags
    // ----------------------------------------
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            data_buffer_reg <= 8'h00;
            received_ninth_bit <= 1'b0;
            tx_done_flag <= 1'b0;
            rx_done_flag <= 1'b0;
        end else if (CE_I) begin
            // a refused frame touches nothing, so no else branch
            if (rx_load) begin
                data_buffer_reg <= rx_data;
                // stop bit in the short format, ninth bit in the long one
                received_ninth_bit <= rx_check_bit;
            end
            tx_done_flag <= flag_next(tx_done_flag, tx_enter_stop, clr_tx);
            rx_done_flag <= flag_next(rx_done_flag, rx_load, clr_rx);
        end
    end

    // ----------------------------------------
    // interrupt output
    // ----------------------------------------
    // level, high while any unmasked done flag is set
    // registered so the pin cannot glitch; costs one cycle of latency
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            IRQ_O <= 1'b0;
        end else if (CE_I) begin
            IRQ_O <= |({rx_done_flag, tx_done_flag} & mask_reg);
        end
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    // one strobe feeds both the flag and the state machine, so they agree
    // on the edge at which the stop bit begins
    assign tx_enter_stop = CE_I & tx_state_reg[2] & BAUD_TICK_I &
        (tx_tick_reg == `ASU_OVS_LAST) &
        (tx_bit_reg == (tx_nine_reg ? `ASU_LAST_BIT9 : `ASU_LAST_BIT8));

    // start bit waits for the next tick, so its length may be short by
    // up to one tick; the following bits are exactly sixteen ticks
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            tx_state_reg <= TX_IDLE;
            tx_tick_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
            tx_shift_reg <= 9'h000;
            tx_nine_reg <= 1'b0;
            SERIAL_OUT_PIN_O <= 1'b1;
        end else if (CE_I) begin
            case (tx_state_reg)
                TX_IDLE: begin
                    SERIAL_OUT_PIN_O <= 1'b1;
                    if (tx_go) begin
                        // ninth bit and format frozen for the whole frame
                        tx_shift_reg <= {tx_ninth_bit, PWDATA_I[7:0]};
                        tx_nine_reg <= frame_length_select;
                        tx_tick_reg <= 4'h0;
                        tx_bit_reg <= 4'h0;
                        SERIAL_OUT_PIN_O <= 1'b0;
                        tx_state_reg <= TX_START;
                    end
                end
                TX_START: begin
                    if (BAUD_TICK_I) begin
                        if (tx_tick_reg == `ASU_OVS_LAST) begin
                            tx_tick_reg <= 4'h0;
                            SERIAL_OUT_PIN_O <= tx_shift_reg[0];
                            tx_state_reg <= TX_DATA;
                        end else begin
                            tx_tick_reg <= tx_tick_reg + 4'h1;
                        end
                    end
                end
                TX_DATA: begin
                    if (BAUD_TICK_I) begin
                        if (tx_tick_reg == `ASU_OVS_LAST) begin
                            tx_tick_reg <= 4'h0;
                            if (tx_enter_stop) begin
                                SERIAL_OUT_PIN_O <= 1'b1;
                                tx_state_reg <= TX_STOP;
                            end else begin
                                // least significant bit first
                                SERIAL_OUT_PIN_O <= tx_shift_reg[tx_bit_reg + 4'h1];
                                tx_bit_reg <= tx_bit_reg + 4'h1;
                            end
                        end else begin
                            tx_tick_reg <= tx_tick_reg + 4'h1;
                        end
                    end
                end
                TX_STOP: begin
                    SERIAL_OUT_PIN_O <= 1'b1;
                    if (BAUD_TICK_I) begin
                        if (tx_tick_reg == `ASU_OVS_LAST) begin
                            tx_tick_reg <= 4'h0;
                            tx_state_reg <= TX_IDLE;
                        end else begin
                            tx_tick_reg <= tx_tick_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- verification/asu_peer.sv ----
// line partner: a second transceiver that sends frames and captures replies
// assumes: same clock as the block; one bit lasts BIT_CYC clock cycles
`default_nettype none
module asu_peer #(
    parameter int BIT_CYC = 32
) (
    input wire logic clk_i,
    input wire logic nine_i,
    input wire logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] got = 10'h0; // last captured frame, stop bit on top
    int n_got = 0; // frames captured
    initial line_o = 1'b1;
    // start, data lsb first, ninth if set, stop; stop low breaks framing on purpose
    task automatic send(input logic [8:0] d, input logic stop);
        logic [10:0] f;
        f = nine_i ? {stop, d, 1'b0} : {1'b0, stop, d[7:0], 1'b0};
        for (int i = 0; i < (nine_i ? 11 : 10); i++) begin
            line_o <= f[i];
            repeat (BIT_CYC) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask
    // centre sampling after a falling edge
    always begin
        @(negedge line_i);
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < (nine_i ? 10 : 9); i++) begin
            repeat (BIT_CYC) @(posedge clk_i);
            got[i] = line_i;
        end
        n_got++;
    end
endmodule
`default_nettype wire

// ---- verification/asu_top_sva.sv ----
// checker for the serial transceiver top: bus handshake and line timing
// assumes: bound to asu_top, one clock domain, CE_I low only while the bus is idle
`default_nettype none
module asu_chk (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic SERIAL_OUT_PIN_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    // exactly one wait state
    property p_rdy; $rose(PENABLE_I) && PSEL_I && CE_I |=> PREADY_O; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_pulse; PREADY_O |=> !PREADY_O; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_err; PSLVERR_O |-> PREADY_O; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_map; PREADY_O && PADDR_I <= 8'h0C && PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O; endproperty
    a_map: assert property (p_map) else $error("error on mapped word");
    // unmapped reads return zero, writes just flag
    property p_unm; PREADY_O && PADDR_I > 8'h0C |-> PSLVERR_O && (PWRITE_I || PRDATA_O == 0); endproperty
    a_unm: assert property (p_unm) else $error("unmapped not refused");
    property p_hi; PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_rst; $fell(RST_I) |-> SERIAL_OUT_PIN_O && !IRQ_O; endproperty
    a_rst: assert property (p_rst) else $error("line not idle after reset");
    // a start bit lasts far longer than eight cycles at any tick rate
    property p_start; $fell(SERIAL_OUT_PIN_O) |-> !SERIAL_OUT_PIN_O [*8]; endproperty
    a_start: assert property (p_start) else $error("start bit short");
    // flags are only set by hardware, so irq drops only after a bus write
    property p_irq; $fell(IRQ_O) |-> $past(PREADY_O && PWRITE_I, 2); endproperty
    a_irq: assert property (p_irq) else $error("irq dropped alone");
endmodule
bind asu_top asu_chk i_chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CE_I(CE_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ---- verification/test_async_serial_8_9_bit.sv ----
// bench for the serial transceiver: apb register tests and line traffic
// assumes: asu_top and asu_peer compiled first; checker bound separately
`default_nettype none
module test_async_serial_8_9_bit;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, tick = 0, psel = 0, pen = 0, pwr = 0, nine = 0, ce = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, rxd, txd, irq, err;
    int miscompares = 0;
    int n_compared = 0;
    int base;
    asu_top i_dut (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .BAUD_TICK_I(tick),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .SERIAL_IN_PIN_I(rxd), .SERIAL_OUT_PIN_O(txd), .IRQ_O(irq));
    asu_peer #(.BIT_CYC(32)) i_peer (.clk_i(clk), .nine_i(nine), .line_i(txd), .line_o(rxd));
    initial forever #5 clk = ~clk;
    // tick every second cycle, so one bit is 32 cycles
    always @(posedge clk) tick <= ~tick;
    task automatic stop_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // one transfer, entered just after a rising edge; held until ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("ready", 32'h1, {31'h0, pready});
        if (pready !== 1'b1) stop_test();
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk);
        chk("irq wait", 32'h1, {31'h0, irq});
        if (irq !== 1'b1) stop_test();
    endtask
    // poll the busy bit until the stop bit is over
    task automatic wait_idle();
        r = 32'h8;
        for (int n = 0; n < 200 && r[3] !== 1'b0; n++) apb(1'b0, 8'h08, 32'h0);
        chk("busy", 32'h0, {31'h0, r[3]});
        if (r[3] !== 1'b0) stop_test();
    endtask
    // peer sends one frame; status, irq and buffer then compared
    task automatic rx_case(input logic clr, input logic [7:0] ctl, input logic [8:0] d,
        input logic stop, input logic [7:0] es, input logic [7:0] ed);
        // format settles in the peer well before its first bit is built
        nine <= ctl[7];
        if (clr) apb(1'b1, 8'h08, 32'h3);
        apb(1'b1, 8'h00, {24'h0, ctl});
        i_peer.send(d, stop);
        apb(1'b0, 8'h08, 32'h0);
        chk("stat", {24'h0, es}, r);
        chk("irq", {31'h0, es[1]}, {31'h0, irq});
        apb(1'b0, 8'h04, 32'h0);
        chk("data", {24'h0, ed}, r);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // reset values, then one unmapped word
        for (int a = 0; a <= 16; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk("reset read", 32'h0, r);
            chk("slverr", {31'h0, a == 16}, {31'h0, err});
        end
        // 8-bit transmit with its irq enabled
        apb(1'b1, 8'h0C, 32'h1);
        base = i_peer.n_got;
        apb(1'b1, 8'h04, 32'hA5);
        wait_irq();
        chk("line at done", 32'h1, {31'h0, txd});
        chk("frames at done", base, i_peer.n_got);
        // clock enable low in the stop bit: irq and line must hold
        ce <= 1'b0;
        repeat (8) @(posedge clk);
        chk("irq frozen", 32'h1, {31'h0, irq});
        chk("line frozen", 32'h1, {31'h0, txd});
        ce <= 1'b1;
        wait_idle();
        chk("tx8", 32'h1A5, {23'h0, i_peer.got[8:0]});
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk("stat", 32'h0, r);
        chk("irq", 32'h0, {31'h0, irq});
        // 9-bit transmit, tx irq masked, second write while busy dropped
        apb(1'b1, 8'h0C, 32'h2);
        apb(1'b1, 8'h00, 32'h88);
        nine <= 1'b1;
        apb(1'b1, 8'h04, 32'h3C);
        apb(1'b1, 8'h04, 32'h55);
        wait_idle();
        chk("tx9", 32'h33C, {22'h0, i_peer.got});
        chk("frames", base + 2, i_peer.n_got);
        apb(1'b0, 8'h08, 32'h0);
        chk("stat", 32'h1, r);
        chk("irq", 32'h0, {31'h0, irq});
        // receive: accept, overrun, refusals by the check bit, disabled receiver
        rx_case(1'b1, 8'h10, 9'h05A, 1'b1, 8'h06, 8'h5A);
        rx_case(1'b0, 8'h10, 9'h0C3, 1'b1, 8'h06, 8'h5A);
        rx_case(1'b1, 8'h30, 9'h0C3, 1'b0, 8'h04, 8'h5A);
        rx_case(1'b1, 8'h30, 9'h1E1, 1'b1, 8'h06, 8'hE1);
        rx_case(1'b1, 8'hB0, 9'h066, 1'b1, 8'h04, 8'hE1);
        rx_case(1'b1, 8'hB0, 9'h181, 1'b0, 8'h06, 8'h81);
        rx_case(1'b1, 8'h90, 9'h042, 1'b1, 8'h02, 8'h42);
        rx_case(1'b1, 8'h80, 9'h1FF, 1'b1, 8'h00, 8'h42);
        stop_test();
    end
endmodule
`default_nettype wire
